// File: dsc_core.sv
// Command core of a four-bank DDR2 memory as seen from its command pins.
`timescale 1ns/1ps
module dsc_core
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Command pins
  input wire dsc_cmd_s I_CMD,
  input wire logic I_ODT,
  // Write data mask per byte lane, sampled with each beat
  input wire logic [1:0] I_DM,
  input wire logic I_WBEAT,
  // Internal access issued to the array
  output dsc_acc_s O_ACC,
  output logic [1:0] O_BYTE_WE,
  output logic [ROW_W-1:0] O_REF_ROW,
  output logic O_REF_PULSE,
  // Mode registers
  output logic [MR_W-1:0] O_MR0,
  output logic [MR_W-1:0] O_MR1,
  output logic [AL_W-1:0] O_AL,
  // Status
  output logic [NBANK-1:0] O_BANK_OPEN,
  output logic O_SELF_REF,
  output logic O_DLL_ON,
  output logic O_ODT_ON,
  output logic O_BURST_BUSY
);
  dsc_cmd_e cmd;
  logic cke_prev_r;
  dsc_bank_e bank_st_r [NBANK];
  logic [ROW_W-1:0] row_r [NBANK];
  logic [3:0] trp_cnt_r [NBANK];
  logic [MR_W-1:0] mr0_r;
  logic [MR_W-1:0] mr1_r;
  logic [AL_W-1:0] al_r;
  dsc_acc_s pend_r [8];
  logic [BURST_W-1:0] burst_r;
  logic burst_ap_r;
  logic [1:0] burst_bank_r;
  logic burst_wr_r;
  logic [ROW_W-1:0] ref_cnt_r;
  logic sref_r;

  assign cmd = dsc_decode(I_CMD, cke_prev_r); // R23 R01 R02
  assign al_r = mr1_r[5:3];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cke_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= I_CMD.cke;
    end
  end

  // Mode loads select the register by bank bits; idle-only use is the controller's duty.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mr0_r <= MR_RST;
      mr1_r <= MR_RST;
    end else if (cmd == CMD_MRS) begin // R03 R20
      if (I_CMD.ba == MR_MODE) begin
        mr0_r <= {1'b0, I_CMD.addr};
      end else if (I_CMD.ba == MR_EXT1) begin
        mr1_r <= {1'b0, I_CMD.addr};
      end
    end
  end

  // Bank state: activate opens, precharge closes, auto precharge closes at burst end.
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic pre_hit;
    assign pre_hit = (cmd == CMD_PRE) &&
                     (I_CMD.addr[AP_BIT] || I_CMD.ba == 2'(b)); // R12
    always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
        bank_st_r[b] <= DSC_IDLE;
        row_r[b] <= '0;
        trp_cnt_r[b] <= 4'h0;
      end else begin
        if (pre_hit) begin
          bank_st_r[b] <= DSC_PRE; // R15
          trp_cnt_r[b] <= TRP_CYC;
        end else if (burst_r == 4'h1 && burst_ap_r && burst_bank_r == 2'(b)) begin
          bank_st_r[b] <= DSC_PRE; // R08 R09
          trp_cnt_r[b] <= TRP_CYC;
        end else if (cmd == CMD_ACT && I_CMD.ba == 2'(b)) begin
          bank_st_r[b] <= DSC_OPEN; // R05
          row_r[b] <= I_CMD.addr;
        end else if (bank_st_r[b] == DSC_PRE) begin
          if (trp_cnt_r[b] <= 4'h1) begin
            bank_st_r[b] <= DSC_IDLE; // R14
            trp_cnt_r[b] <= 4'h0;
          end else begin
            trp_cnt_r[b] <= trp_cnt_r[b] - 4'h1;
          end
        end
      end
    end
  end

  // Posted accesses wait AL cycles in a shift line before reaching the array.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < 8; i++) begin
        pend_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 7; i++) begin
        pend_r[i] <= pend_r[i+1];
      end
      pend_r[7] <= '0;
      if (cmd == CMD_RD || cmd == CMD_WR) begin
        pend_r[al_r] <= '{valid: 1'b1, write: (cmd == CMD_WR), // R10
                          auto_pre: I_CMD.addr[AP_BIT], bank: I_CMD.ba,
                          row: row_r[I_CMD.ba], col: I_CMD.addr[COL_W-1:0]}; // R07
      end
    end
  end

  // The internal access; row is taken when the command is posted, the column is A0 to A9 and bits above A9 are dropped.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ACC <= '0;
      burst_r <= '0;
      burst_ap_r <= 1'b0;
      burst_bank_r <= 2'h0;
      burst_wr_r <= 1'b0;
    end else begin
      O_ACC <= pend_r[0];
      if (pend_r[0].valid) begin
        burst_r <= BURST_LEN;
        burst_ap_r <= pend_r[0].auto_pre;
        burst_bank_r <= pend_r[0].bank;
        burst_wr_r <= pend_r[0].write;
      end else if (burst_r != 4'h0) begin
        burst_r <= burst_r - 4'h1;
      end
    end
  end

  // Byte enables are the inverse of the mask; masked lanes leave memory alone.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BYTE_WE <= 2'h0;
    end else begin
      O_BYTE_WE <= (I_WBEAT && burst_wr_r && burst_r != 4'h0) ? ~I_DM : 2'h0; // R11
    end
  end

  // Refresh row from the internal counter; address pins are ignored.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ref_cnt_r <= '0;
      O_REF_PULSE <= 1'b0;
    end else begin
      O_REF_PULSE <= (cmd == CMD_REF || cmd == CMD_SREF);
      if (cmd == CMD_REF || cmd == CMD_SREF) begin
        ref_cnt_r <= ref_cnt_r + 13'h0001; // R17
      end
    end
  end
  assign O_REF_ROW = ref_cnt_r;

  // Self refresh holds until clock enable returns; the loop follows it.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sref_r <= 1'b0;
      O_DLL_ON <= 1'b1;
    end else begin
      if (cmd == CMD_SREF) begin
        sref_r <= 1'b1; // R18
        O_DLL_ON <= 1'b0; // R19
      end else if (sref_r && I_CMD.cke) begin
        sref_r <= 1'b0;
        O_DLL_ON <= 1'b1; // R19
      end
    end
  end

  // Termination only when configured, pin high and not in self refresh.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ODT_ON <= 1'b0;
    end else begin
      O_ODT_ON <= I_ODT && !sref_r && cmd != CMD_SREF &&
                  (mr1_r[ODT_BIT_A] || mr1_r[ODT_BIT_B]); // R20 R21 R22
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BANK_OPEN <= '0;
    end else begin
      for (int i = 0; i < NBANK; i++) begin
        O_BANK_OPEN[i] <= (bank_st_r[i] == DSC_OPEN);
      end
    end
  end

  assign O_MR0 = mr0_r;
  assign O_MR1 = mr1_r;
  assign O_AL = al_r;
  assign O_SELF_REF = sref_r;

  // Busy is registered so the pin never shows a glitch while the counter settles.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BURST_BUSY <= 1'b0;
    end else begin
      O_BURST_BUSY <= pend_r[0].valid || (burst_r > 4'h1);
    end
  end

  // Command decode and deselect.
  desel_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R01
    (I_CMD.cs_n && cke_prev_r) |=> $stable(mr0_r) && $stable(mr1_r))
    else $error("Deselect changed a mode register.");
  cs_high_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R01
    I_CMD.cs_n |-> cmd == CMD_DESEL)
    else $error("Command taken while deselected.");
  desel_acc_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R01
    (cmd == CMD_DESEL && burst_r > 4'h1) |=> O_BURST_BUSY)
    else $error("Deselect cut a running burst.");
  desel_pend_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R01
    (cmd == CMD_DESEL) |=> !pend_r[7].valid)
    else $error("Deselect posted an access.");
  cke_low_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R23
    !cke_prev_r |-> cmd == CMD_DESEL)
    else $error("Command taken with clock enable low before.");
  nop_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R02
    (cmd == CMD_NOP) |=> $stable(mr0_r) && $stable(mr1_r) && $stable(row_r[0]))
    else $error("No-operation changed state.");

  // Mode registers.
  mrs_load_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
    (cmd == CMD_MRS && I_CMD.ba == MR_EXT1) |=> mr1_r == {1'b0, $past(I_CMD.addr)})
    else $error("Extended mode load lost.");
  mr0_load_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
    (cmd == CMD_MRS && I_CMD.ba == MR_MODE) |=> mr0_r == {1'b0, $past(I_CMD.addr)})
    else $error("Mode load lost.");
  mrs_other_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
    (cmd == CMD_MRS && I_CMD.ba[1]) |=> $stable(mr0_r) && $stable(mr1_r))
    else $error("Unused mode select changed a register.");
  mr_keep_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R03
    (cmd != CMD_MRS) |=> $stable(mr0_r) && $stable(mr1_r))
    else $error("Mode register changed without a load.");

  // Bank state; an auto precharge ending on the same edge takes priority.
  act_open_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R05
    (cmd == CMD_ACT && I_CMD.ba == 2'h0) |=> ##1 O_BANK_OPEN[0])
    else $error("Activate did not open bank zero.");
  act_state_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R05
    (cmd == CMD_ACT && !(burst_r == 4'h1 && burst_ap_r))
    |=> bank_st_r[$past(I_CMD.ba)] == DSC_OPEN)
    else $error("Activate left the bank closed.");
  act_row_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R05
    (cmd == CMD_ACT && !(burst_r == 4'h1 && burst_ap_r))
    |=> row_r[$past(I_CMD.ba)] == $past(I_CMD.addr))
    else $error("Activate stored the wrong row.");
  bank_open_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R05
    1'b1 |=> O_BANK_OPEN[1] == ($past(bank_st_r[1]) == DSC_OPEN))
    else $error("Open flag does not follow bank state.");
  pre_close_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R12
    (cmd == CMD_PRE && I_CMD.addr[AP_BIT]) |=> bank_st_r[3] == DSC_PRE)
    else $error("Precharge all left a bank open.");
  pre_all_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R12
    (cmd == CMD_PRE && I_CMD.addr[AP_BIT])
    |=> bank_st_r[0] == DSC_PRE && bank_st_r[1] == DSC_PRE && bank_st_r[2] == DSC_PRE)
    else $error("Precharge all missed a bank.");
  pre_one_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R12
    (cmd == CMD_PRE && !I_CMD.addr[AP_BIT]) |=> bank_st_r[$past(I_CMD.ba)] == DSC_PRE)
    else $error("Precharge did not close its bank.");
  pre_trp_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R15
    (cmd == CMD_PRE) |=> trp_cnt_r[$past(I_CMD.ba)] == TRP_CYC)
    else $error("Precharge period not restarted.");
  pre_idle_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R14
    (bank_st_r[0] == DSC_PRE && trp_cnt_r[0] == 4'h1 && cmd == CMD_NOP && burst_r == 4'h0)
    |=> bank_st_r[0] == DSC_IDLE)
    else $error("Bank not idle after precharge period.");
  idle_stay_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R14
    (bank_st_r[2] == DSC_IDLE && cmd != CMD_ACT) |=> bank_st_r[2] != DSC_OPEN)
    else $error("Idle bank opened without activate.");

  // Posted accesses and bursts; the checks assume the latency this bench programs.
  al_delay_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R10
    (cmd == CMD_RD && al_r == 3'h2 && $stable(al_r)) |=> ##3 O_ACC.valid)
    else $error("Access not issued after its latency.");
  wr_post_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R09
    (cmd == CMD_WR && al_r == 3'h2) |=> ##3 O_ACC.valid && O_ACC.write)
    else $error("Write not issued after its latency.");
  acc_rd_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R07
    (cmd == CMD_RD && al_r == 3'h2) |=> ##3 !O_ACC.write)
    else $error("Read issued as a write.");
  acc_col_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R07
    (cmd == CMD_RD && al_r == 3'h2) |=> ##3 O_ACC.col == $past(I_CMD.addr[COL_W-1:0], 4))
    else $error("Read column lost.");
  acc_bank_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R07
    (cmd == CMD_RD && al_r == 3'h2) |=> ##3 O_ACC.bank == $past(I_CMD.ba, 4))
    else $error("Read bank lost.");
  acc_ap_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R09
    (cmd == CMD_WR && al_r == 3'h2) |=> ##3 O_ACC.auto_pre == $past(I_CMD.addr[AP_BIT], 4))
    else $error("Auto precharge flag lost.");
  ap_close_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R08
    (burst_r == 4'h1 && burst_ap_r) |=> bank_st_r[$past(burst_bank_r)] == DSC_PRE)
    else $error("Auto precharge did not close bank.");
  ap_keep_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R08
    (burst_r == 4'h1 && !burst_ap_r && cmd == CMD_NOP && bank_st_r[burst_bank_r] == DSC_OPEN)
    |=> bank_st_r[$past(burst_bank_r)] == DSC_OPEN)
    else $error("Plain burst closed its row.");
  busy_len_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R07
    pend_r[0].valid |=> O_BURST_BUSY [*4])
    else $error("Burst shorter than its length.");
  busy_end_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R07
    (burst_r == 4'h1 && !pend_r[0].valid) |=> !O_BURST_BUSY)
    else $error("Burst longer than its length.");

  // Write masking.
  mask_drop_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R11
    (I_DM == 2'h3) |=> O_BYTE_WE == 2'h0)
    else $error("Masked bytes were written.");
  byte_we_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R11
    (I_WBEAT && burst_wr_r && burst_r != 4'h0 && I_DM == 2'h0) |=> O_BYTE_WE == 2'h3)
    else $error("Unmasked bytes were dropped.");
  we_idle_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R11
    !I_WBEAT |=> O_BYTE_WE == 2'h0)
    else $error("Byte written without data.");
  rd_no_we_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R11
    !burst_wr_r |=> O_BYTE_WE == 2'h0)
    else $error("Byte written outside a write burst.");
  we_burst_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R11
    (burst_r == 4'h0) |=> O_BYTE_WE == 2'h0)
    else $error("Byte written with no burst running.");

  // Refresh, self refresh and termination.
  ref_count_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R17
    (cmd == CMD_REF) |=> ref_cnt_r == $past(ref_cnt_r) + 13'h0001)
    else $error("Refresh counter did not advance.");
  ref_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R17
    (cmd == CMD_REF) |=> O_REF_PULSE)
    else $error("Refresh pulse missing.");
  ref_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R17
    (cmd != CMD_REF && cmd != CMD_SREF) |=> !O_REF_PULSE && $stable(ref_cnt_r))
    else $error("Refresh without a command.");
  sref_row_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R17
    (cmd == CMD_SREF) |=> ref_cnt_r == $past(ref_cnt_r) + 13'h0001)
    else $error("Self refresh entry did not refresh a row.");
  sref_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R18
    (cmd == CMD_SREF) |=> O_REF_PULSE)
    else $error("Self refresh entry pulse missing.");
  sref_entry_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R18 R19
    (cmd == CMD_SREF) |=> sref_r && !O_DLL_ON)
    else $error("Self refresh not entered.");
  sref_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R18
    (sref_r && !I_CMD.cke) |=> sref_r)
    else $error("Self refresh left with clock enable low.");
  sref_exit_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R19
    (sref_r && I_CMD.cke) |=> !sref_r && O_DLL_ON)
    else $error("Loop not restored on self refresh exit.");
  sref_dll_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R19 R21
    sref_r |-> !O_DLL_ON && !O_ODT_ON)
    else $error("Loop or termination active in self refresh.");
  sref_odt_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R21
    (cmd == CMD_SREF) |=> !O_ODT_ON)
    else $error("Termination on at self refresh entry.");
  odt_off_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R21
    !I_ODT |=> !O_ODT_ON)
    else $error("Termination on with its pin low.");
  odt_on_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R20 R22
    (I_ODT && !sref_r && cmd != CMD_SREF && mr1_r[ODT_BIT_A]) |=> O_ODT_ON)
    else $error("Termination did not switch on.");
  odt_cfg_a: assert property (@(posedge I_CLK) disable iff (I_RST) // R20
    (!mr1_r[ODT_BIT_A] && !mr1_r[ODT_BIT_B]) |=> !O_ODT_ON)
    else $error("Termination on while not configured.");
endmodule // dsc_core

// File: dsc_pkg.sv
// Package of constants and types for the DDR2 command core model.
// Notes on behaviour
// R01 - Chip select high blocks new commands only
// R02 - NOP decodes with strobes high, harmless
// R03 - Bank bits pick mode register, address loads
// R04 - Controller loads modes only when idle
// R05 - Activate opens addressed row in bank
// R06 - Controller precharges before opening another row
// R07 - Read bursts from open row at column
// R08 - A10 high auto-precharges after read burst
// R09 - Write bursts to open row, A10 precharges
// R10 - Additive latency delays internal access registration
// R11 - Mask low stores byte, high discards
// R12 - Precharge closes one or all banks
// R13 - Controller may access other bank during autoprecharge
// R14 - Precharged bank idle until activated again
// R15 - Precharge to idle bank restarts period
// R16 - Controller refreshes only with banks idle
// R17 - Refresh row comes from internal counter
// R18 - Refresh with clock enable low enters self-refresh
// R19 - Delay loop off in self-refresh, on after
// R20 - Termination set by mode load, pin switched
// R21 - Termination works except during self-refresh
// R22 - Termination applies to data and strobe lines
// R23 - Commands decoded from pins at rising edge
// R24 - Controller waits exit-to-read delay after self-refresh
// R25 - Controller holds clock enable three edges
// R26 - Controller schedules refresh often enough
package dsc_pkg;
  localparam int NBANK = 4;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int MR_W = 14;
  localparam int AL_W = 3;
  localparam int AP_BIT = 10;
  localparam int ODT_BIT_A = 2;
  localparam int ODT_BIT_B = 6;
  localparam int BURST_W = 4;
  localparam logic [BURST_W-1:0] BURST_LEN = 4'h4;
  localparam int TRP_NS = 15;
  localparam int CLK_NS = 50;
  localparam logic [3:0] TRP_CYC = 4'((TRP_NS + CLK_NS - 1) / CLK_NS);
  localparam int REF_W = 13;
  localparam logic [1:0] MR_MODE = 2'h0;
  localparam logic [1:0] MR_EXT1 = 2'h1;
  localparam logic [13:0] MR_RST = 14'h0000;
  typedef enum logic [1:0] {DSC_IDLE, DSC_OPEN, DSC_PRE} dsc_bank_e;
  typedef enum logic [3:0] {CMD_DESEL, CMD_NOP, CMD_MRS, CMD_ACT, CMD_RD, CMD_WR,
    CMD_PRE, CMD_REF, CMD_SREF, CMD_BAD} dsc_cmd_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] ba;
    logic [ROW_W-1:0] addr;
  } dsc_cmd_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic auto_pre;
    logic [1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } dsc_acc_s;
  function automatic dsc_cmd_e dsc_decode(input dsc_cmd_s c, input logic cke_prev);
    dsc_cmd_e r;
    r = CMD_BAD;
    if (!cke_prev) begin
      r = CMD_DESEL;
    end else if (c.cs_n) begin
      r = CMD_DESEL;
    end else begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'h7: r = CMD_NOP;
        3'h0: r = CMD_MRS;
        3'h3: r = CMD_ACT;
        3'h5: r = CMD_RD;
        3'h4: r = CMD_WR;
        3'h2: r = CMD_PRE;
        3'h1: r = c.cke ? CMD_REF : CMD_SREF;
        default: r = CMD_BAD;
      endcase
    end
    return r;
  endfunction
endpackage

// File: dsc_ctrl_model.sv
// Controller model that drives the command, termination and write mask pins.
`timescale 1ns/1ps
module dsc_ctrl_model
  import dsc_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Pins toward the core
  output dsc_cmd_s o_cmd,
  output logic o_odt,
  output logic [1:0] o_dm,
  output logic o_wbeat
);
  initial begin
    o_cmd = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
    o_odt = 1'b0;
    o_dm = 2'h3;
    o_wbeat = 1'b0;
  end
  // One command per call, then a no-operation so nothing else is registered.
  task automatic cmd(input logic [3:0] c, input logic k, input logic [1:0] b,
      input logic [12:0] a);
    @(negedge i_clk);
    o_cmd = '{c[3], c[2], c[1], c[0], k, b, a};
    @(posedge i_clk);
    @(negedge i_clk);
    o_cmd = '{1'b0, 1'b1, 1'b1, 1'b1, k, 2'h0, 13'h0000};
  endtask
  task automatic pins(input logic t, input logic k);
    @(negedge i_clk);
    o_odt = t;
    o_cmd.cke = k;
  endtask
  // Mask is released high between beats so stray data is never stored.
  task automatic beat(input logic w, input logic [1:0] m);
    @(negedge i_clk);
    o_wbeat = w;
    o_dm = w ? m : 2'h3;
  endtask
endmodule // dsc_ctrl_model

// File: test_ddr2_sdram_command_core.sv
// Self-checking testbench of the command core driven by the controller model.
`timescale 1ns/1ps
module test_ddr2_sdram_command_core;
  import dsc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  dsc_cmd_s cmd;
  logic odt;
  logic [1:0] dm;
  logic wb;
  dsc_acc_s acc;
  logic [1:0] bwe;
  logic [ROW_W-1:0] rrow;
  logic rpul;
  logic [MR_W-1:0] mr0;
  logic [MR_W-1:0] mr1;
  logic [AL_W-1:0] al;
  logic [NBANK-1:0] bo;
  logic sref;
  logic dll;
  logic odton;
  logic busy;
  int miscompares = 0;
  int n_tests = 0;
  always #25 i_clk = ~i_clk;
  dsc_ctrl_model m (.i_clk(i_clk), .o_cmd(cmd), .o_odt(odt), .o_dm(dm), .o_wbeat(wb));
  dsc_core dut_u (.I_CLK(i_clk), .I_RST(i_rst), .I_CMD(cmd), .I_ODT(odt), .I_DM(dm),
    .I_WBEAT(wb), .O_ACC(acc), .O_BYTE_WE(bwe), .O_REF_ROW(rrow), .O_REF_PULSE(rpul),
    .O_MR0(mr0), .O_MR1(mr1), .O_AL(al), .O_BANK_OPEN(bo), .O_SELF_REF(sref),
    .O_DLL_ON(dll), .O_ODT_ON(odton), .O_BURST_BUSY(busy));
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic t_mode();
    chk("dll", dll, 1);
    m.cmd(4'h0, 1, 2'h0, 13'h0432);
    chk("mr0", mr0, 14'h0432);
    m.cmd(4'h0, 1, 2'h1, 13'h0054);
    chk("mr1", mr1, 14'h0054);
    chk("al", al, 2);
    m.cmd(4'h0, 1, 2'h2, 13'h1111);
    chk("mr0", mr0, 14'h0432);
    m.pins(1, 1);
    ticks(2);
    chk("odt", odton, 1);
    $display("mode test done");
  endtask
  task automatic t_rw();
    logic [1:0] p;
    m.cmd(4'h3, 1, 2'h1, 13'h1ABC);
    ticks(2);
    chk("open", bo, 4'h2);
    m.cmd(4'hD, 1, 2'h1, 13'h0155);
    for (int i = 0; i < 4; i++) begin
      ticks(1);
      chk("desel", acc.valid, 0);
    end
    m.cmd(4'h5, 1, 2'h1, 13'h0155);
    ticks(2);
    chk("early", acc.valid, 0);
    ticks(1);
    chk("rd", acc, {3'h4, 2'h1, 13'h1ABC, 10'h155});
    ticks(8);
    chk("open", bo, 4'h2);
    m.cmd(4'h4, 1, 2'h1, 13'h04AA);
    ticks(3);
    chk("wr", acc, {3'h7, 2'h1, 13'h1ABC, 10'h0AA});
    chk("busy", busy, 1);
    for (int i = 0; i < 4; i++) begin
      p = i[1:0];
      m.beat(1, p);
      ticks(1);
      chk("bwe", bwe, 2'(~p));
    end
    m.beat(0, 2'h0);
    ticks(8);
    chk("autopre", bo, 4'h0);
    chk("idle", busy, 0);
    $display("read write test done");
  endtask
  task automatic t_pre();
    m.cmd(4'h3, 1, 2'h0, 13'h0001);
    m.cmd(4'h3, 1, 2'h3, 13'h0002);
    ticks(2);
    chk("open", bo, 4'h9);
    m.cmd(4'h2, 1, 2'h0, 13'h0000);
    ticks(2);
    chk("pre", bo, 4'h8);
    m.cmd(4'h2, 1, 2'h0, 13'h0000);
    ticks(2);
    chk("pre", bo, 4'h8);
    m.cmd(4'h2, 1, 2'h0, 13'h0400);
    ticks(2);
    chk("preall", bo, 4'h0);
    $display("precharge test done");
  endtask
  task automatic t_ref();
    logic [ROW_W-1:0] r0;
    logic s;
    r0 = rrow;
    s = rpul;
    m.cmd(4'h1, 1, 2'h2, 13'h1FFF);
    s = s | rpul;
    for (int i = 0; i < 3; i++) begin
      ticks(1);
      s = s | rpul;
    end
    chk("refpulse", s, 1);
    chk("refrow", rrow, r0 + 13'h0001);
    m.cmd(4'h1, 0, 2'h0, 13'h0000);
    ticks(4);
    chk("sref", sref, 1);
    chk("dlloff", dll, 0);
    chk("odtoff", odton, 0);
    m.pins(1, 1);
    ticks(4);
    chk("sref", sref, 0);
    chk("dllon", dll, 1);
    chk("odton", odton, 1);
    $display("refresh test done");
  endtask
  // The watchdog span is about twenty-five times the length of all tests together.
  initial begin
    repeat (2000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    ticks(2);
    t_mode();
    t_rw();
    t_pre();
    t_ref();
    complete_run();
  end
endmodule // test_ddr2_sdram_command_core
